// File: design/albd_decoder.sv
// Operation
// - Decode conjunction in its three forms
// - Test forms set flags, never write result
// - Decode inclusive disjunction in three forms
// - Decode exclusive disjunction in three forms
// - Immediate logical: second data byte if word, except the sign-extended immediate-group form
// - Decode string load into accumulator, width-selected
// - Branch on zero set or clear
// - Branch on sign set or clear
// - Branch signed not-less and greater
// - Branch unsigned not-below and above
// - Branch unsigned below-or-equal
// - Branch parity odd, no overflow
// - Decrement count, loop while nonzero and zero
// - Branch when count is zero, unchanged
// - Width bit word; direction sets destination
// - Sign-width pattern chooses immediate size
// - Mode field selects register or displacement
//
// Decoder: takes a byte stream from the prefetch queue and presents one
// decoded instruction per completed byte sequence to the execution unit.
// Assumes the queue holds a byte until byte_ready is seen with byte_valid.
`timescale 1ns/1ps
`include "albd_consts.svh"
module albd_decoder (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready,
   input wire albd_pkg::albd_arch_type arch,
   output logic instr_valid,
   output albd_pkg::albd_instr_type instr,
   output logic illegal_op,
   output albd_pkg::albd_branch_type branch
);
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [6:0] {
      ST_OPC = 7'h01,
      ST_MODRM = 7'h02,
      ST_DISP_LO = 7'h04,
      ST_DISP_HI = 7'h08,
      ST_IMM_LO = 7'h10,
      ST_IMM_HI = 7'h20,
      ST_DONE = 7'h40
   } albd_state_type;

   albd_state_type state;
   albd_state_type next_state;
   albd_pkg::albd_instr_type cur;
   albd_pkg::albd_instr_type next_cur;
   logic need_imm;
   logic imm_two;
   logic imm_sext;
   logic next_need_imm;
   logic next_imm_two;
   logic next_imm_sext;
   logic disp_two_q;
   albd_pkg::albd_branch_type br_res;

   wire logic take = byte_valid && byte_ready;
   wire logic [7:0] b = byte_data;

   // ----------------------------------------
   // First-byte classification
   // ----------------------------------------
   wire logic is_and_rm = (b & 8'hFC) == `ALBD_AND_RM;
   wire logic is_and_acc = (b & 8'hFE) == `ALBD_AND_ACC;
   wire logic is_imm_grp = (b & 8'hFC) == `ALBD_IMM_RM;
   wire logic is_test_rm = (b & 8'hFE) == `ALBD_TEST_RM;
   wire logic is_test_imm = (b & 8'hFE) == `ALBD_TEST_IMM;
   wire logic is_test_acc = (b & 8'hFE) == `ALBD_TEST_ACC;
   wire logic is_or_rm = (b & 8'hFC) == `ALBD_OR_RM;
   wire logic is_or_acc = (b & 8'hFE) == `ALBD_OR_ACC;
   wire logic is_xor_rm = (b & 8'hFC) == `ALBD_XOR_RM;
   wire logic is_xor_acc = (b & 8'hFE) == `ALBD_XOR_ACC;
   wire logic is_load = (b & 8'hFE) == `ALBD_LOAD_STR;
   logic is_branch;
   albd_pkg::albd_cond_type br_cond;

   always_comb begin
      is_branch = 1'b1;
      br_cond = albd_pkg::ALBD_CC_ZERO;
      unique case (b)
         `ALBD_BR_ZERO: br_cond = albd_pkg::ALBD_CC_ZERO;
         `ALBD_BR_NZERO: br_cond = albd_pkg::ALBD_CC_NZERO;
         `ALBD_BR_NEG: br_cond = albd_pkg::ALBD_CC_NEG;
         `ALBD_BR_NNEG: br_cond = albd_pkg::ALBD_CC_NNEG;
         `ALBD_BR_SGE: br_cond = albd_pkg::ALBD_CC_SGE;
         `ALBD_BR_SGT: br_cond = albd_pkg::ALBD_CC_SGT;
         `ALBD_BR_UGE: br_cond = albd_pkg::ALBD_CC_UGE;
         `ALBD_BR_UGT: br_cond = albd_pkg::ALBD_CC_UGT;
         `ALBD_BR_ULE: br_cond = albd_pkg::ALBD_CC_ULE;
         `ALBD_BR_PODD: br_cond = albd_pkg::ALBD_CC_PODD;
         `ALBD_BR_NOVF: br_cond = albd_pkg::ALBD_CC_NOVF;
         `ALBD_LOOP_EQ: br_cond = albd_pkg::ALBD_CC_LOOPEQ;
         `ALBD_BR_CNT0: br_cond = albd_pkg::ALBD_CC_CNT0;
         default: is_branch = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Second-byte extension for the immediate groups
   // ----------------------------------------
   wire logic [1:0] m_mode = b[7:6];
   wire logic [2:0] m_reg = b[5:3];
   wire logic [2:0] m_rm = b[2:0];
   wire logic grp80 = cur.op == albd_pkg::ALBD_OP_NONE;
   wire logic ext_and = grp80 && (m_reg == `ALBD_EXT_AND);
   wire logic ext_or = grp80 && (m_reg == `ALBD_EXT_OR);
   wire logic ext_xor = grp80 && (m_reg == `ALBD_EXT_XOR);
   wire logic ext_bad_test = (cur.op == albd_pkg::ALBD_OP_TEST) && (cur.form == albd_pkg::ALBD_FORM_IMM_RM)
      && (m_reg != `ALBD_EXT_TEST);
   wire logic ext_bad = (grp80 && !ext_and && !ext_or && !ext_xor) || ext_bad_test;
   // Direct address form carries a 16-bit displacement despite mode 00
   wire logic disp_two = (m_mode == `ALBD_MOD_DISP16)
      || (m_mode == `ALBD_MOD_NODISP && m_rm == `ALBD_RM_DIRECT);
   wire logic disp_one = m_mode == `ALBD_MOD_DISP8;
   albd_state_type after_disp;
   assign after_disp = need_imm ? ST_IMM_LO : ST_DONE;

   // ----------------------------------------
   // Sequencer next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_cur = cur;
      next_need_imm = need_imm;
      next_imm_two = imm_two;
      next_imm_sext = imm_sext;
      unique case (state)
         ST_OPC: begin
            if (take) begin
               next_cur = '0;
               next_cur.word = b[0];
               next_cur.reg_is_dest = b[1];
               next_cur.writes_result = 1'b1;
               next_cur.clears_cf_of = 1'b1;
               next_need_imm = 1'b0;
               next_imm_two = b[0];
               next_imm_sext = 1'b0;
               next_state = ST_MODRM;
               if (is_and_rm || is_or_rm || is_xor_rm) begin
                  next_cur.op = is_and_rm ? albd_pkg::ALBD_OP_AND
                     : is_or_rm ? albd_pkg::ALBD_OP_OR : albd_pkg::ALBD_OP_XOR;
                  next_cur.form = albd_pkg::ALBD_FORM_RM_REG;
               end else if (is_imm_grp) begin
                  // Op resolved from the extension in the next byte
                  next_cur.form = albd_pkg::ALBD_FORM_IMM_RM;
                  next_need_imm = 1'b1;
                  next_imm_sext = b[1] && b[0];
                  next_imm_two = !b[1] && b[0];
                  next_cur.reg_is_dest = 1'b0;
               end else if (is_test_rm || is_test_imm) begin
                  next_cur.op = albd_pkg::ALBD_OP_TEST;
                  next_cur.form = is_test_rm ? albd_pkg::ALBD_FORM_RM_REG : albd_pkg::ALBD_FORM_IMM_RM;
                  next_cur.writes_result = 1'b0;
                  next_cur.reg_is_dest = 1'b0;
                  next_need_imm = is_test_imm;
               end else if (is_and_acc || is_or_acc || is_xor_acc || is_test_acc) begin
                  next_cur.op = is_and_acc ? albd_pkg::ALBD_OP_AND : is_or_acc ? albd_pkg::ALBD_OP_OR
                     : is_xor_acc ? albd_pkg::ALBD_OP_XOR : albd_pkg::ALBD_OP_TEST;
                  next_cur.form = albd_pkg::ALBD_FORM_IMM_ACC;
                  next_cur.writes_result = !is_test_acc;
                  next_cur.reg_is_dest = 1'b0;
                  next_state = ST_IMM_LO;
               end else if (is_load) begin
                  next_cur.op = albd_pkg::ALBD_OP_LOAD_STR;
                  next_cur.reg_is_dest = 1'b0;
                  next_cur.clears_cf_of = 1'b0;
                  next_state = ST_DONE;
               end else if (is_branch) begin
                  next_cur.op = (br_cond == albd_pkg::ALBD_CC_LOOPEQ) ? albd_pkg::ALBD_OP_LOOP
                     : (br_cond == albd_pkg::ALBD_CC_CNT0) ? albd_pkg::ALBD_OP_CNT_BR
                     : albd_pkg::ALBD_OP_BRANCH;
                  next_cur.cond = br_cond;
                  next_cur.word = 1'b0;
                  next_cur.reg_is_dest = 1'b0;
                  next_cur.writes_result = 1'b0;
                  next_cur.clears_cf_of = 1'b0;
                  next_state = ST_DISP_LO;
               end else begin
                  next_cur.writes_result = 1'b0;
                  next_cur.clears_cf_of = 1'b0;
                  next_state = ST_DONE;
               end
            end
         end
         ST_MODRM: begin
            if (take) begin
               next_cur.mode = m_mode;
               next_cur.reg_field = m_reg;
               next_cur.rm_field = m_rm;
               next_cur.rm_is_reg = m_mode == `ALBD_MOD_REG;
               if (ext_and) begin
                  next_cur.op = albd_pkg::ALBD_OP_AND;
               end else if (ext_or) begin
                  next_cur.op = albd_pkg::ALBD_OP_OR;
               end else if (ext_xor) begin
                  next_cur.op = albd_pkg::ALBD_OP_XOR;
               end
               if (ext_bad) begin
                  next_cur.op = albd_pkg::ALBD_OP_NONE;
                  next_cur.writes_result = 1'b0;
                  next_cur.clears_cf_of = 1'b0;
               end
               next_state = (disp_one || disp_two) ? ST_DISP_LO : after_disp;
               next_cur.disp = {16{1'b0}};
            end
         end
         ST_DISP_LO: begin
            if (take) begin
               next_cur.disp = {{8{b[7]}}, b};
               next_state = (cur.op inside {albd_pkg::ALBD_OP_BRANCH, albd_pkg::ALBD_OP_LOOP,
                  albd_pkg::ALBD_OP_CNT_BR} || !disp_two_q) ? after_disp : ST_DISP_HI;
            end
         end
         ST_DISP_HI: begin
            if (take) begin
               next_cur.disp[15:8] = b;
               next_state = after_disp;
            end
         end
         ST_IMM_LO: begin
            if (take) begin
               next_cur.imm = imm_sext ? {{8{b[7]}}, b} : {8'h00, b};
               next_state = imm_two ? ST_IMM_HI : ST_DONE;
            end
         end
         ST_IMM_HI: begin
            if (take) begin
               next_cur.imm[15:8] = b;
               next_state = ST_DONE;
            end
         end
         ST_DONE: next_state = ST_OPC;
      endcase
   end

   // Remember whether the modrm byte asked for a two-byte displacement
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         disp_two_q <= 1'b0;
      end else if (state == ST_MODRM && take) begin
         disp_two_q <= disp_two;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= ST_OPC;
         cur <= '0;
         need_imm <= 1'b0;
         imm_two <= 1'b0;
         imm_sext <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         need_imm <= next_need_imm;
         imm_two <= next_imm_two;
         imm_sext <= next_imm_sext;
      end
   end

   // ----------------------------------------
   // Branch evaluation and registered outputs
   // ----------------------------------------
   albd_branch_eval u_eval (
      .cond(cur.cond),
      .disp(cur.disp[7:0]),
      .arch(arch),
      .result(br_res)
   );

   wire logic is_br_op = cur.op inside {albd_pkg::ALBD_OP_BRANCH, albd_pkg::ALBD_OP_LOOP,
      albd_pkg::ALBD_OP_CNT_BR};
   // Ready is registered from next_state, so it is already low in the done cycle and the queue cannot race ahead
   wire logic next_ready = (next_state != ST_DONE);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         byte_ready <= 1'b0;
         instr_valid <= 1'b0;
         instr <= '0;
         illegal_op <= 1'b0;
         branch <= '0;
      end else begin
         byte_ready <= next_ready;
         instr_valid <= (state == ST_DONE);
         if (state == ST_DONE) begin
            instr <= cur;
            illegal_op <= (cur.op == albd_pkg::ALBD_OP_NONE);
            branch <= is_br_op ? br_res : '0;
         end
      end
   end
endmodule

// File: design/albd_consts.svh
// Opcode patterns, field codes and flag bit positions for the decoder.
// Assumes inclusion by the decoder package users; definitions only.
`ifndef ALBD_CONSTS_SVH
`define ALBD_CONSTS_SVH
// ----------------------------------------
// Opcode patterns (width/direction bits masked for the logic and string forms; branch opcodes are exact)
// ----------------------------------------
`define ALBD_AND_RM 8'h20
`define ALBD_AND_ACC 8'h24
`define ALBD_IMM_RM 8'h80
`define ALBD_TEST_RM 8'h84
`define ALBD_TEST_IMM 8'hF6
`define ALBD_TEST_ACC 8'hA8
`define ALBD_OR_RM 8'h08
`define ALBD_OR_ACC 8'h0C
`define ALBD_XOR_RM 8'h30
`define ALBD_XOR_ACC 8'h34
`define ALBD_LOAD_STR 8'hAC
`define ALBD_BR_ZERO 8'h74
`define ALBD_BR_NZERO 8'h75
`define ALBD_BR_NEG 8'h78
`define ALBD_BR_NNEG 8'h79
`define ALBD_BR_SGE 8'h7D
`define ALBD_BR_SGT 8'h7F
`define ALBD_BR_UGE 8'h73
`define ALBD_BR_UGT 8'h77
`define ALBD_BR_ULE 8'h76
`define ALBD_BR_PODD 8'h7B
`define ALBD_BR_NOVF 8'h71
`define ALBD_LOOP_EQ 8'hE1
`define ALBD_BR_CNT0 8'hE3
// ----------------------------------------
// Extension codes in the reg field
// ----------------------------------------
`define ALBD_EXT_AND 3'h4
`define ALBD_EXT_OR 3'h1
`define ALBD_EXT_XOR 3'h6
`define ALBD_EXT_TEST 3'h0
// ----------------------------------------
// Mode field codes and flag bit positions
// ----------------------------------------
`define ALBD_MOD_NODISP 2'h0
`define ALBD_MOD_DISP8 2'h1
`define ALBD_MOD_DISP16 2'h2
`define ALBD_MOD_REG 2'h3
`define ALBD_RM_DIRECT 3'h6
`define ALBD_FLAG_CF 0
`define ALBD_FLAG_PF 2
`define ALBD_FLAG_ZF 6
`define ALBD_FLAG_SF 7
`define ALBD_FLAG_OF 11
`endif

// File: design/albd_pkg.sv
// Types shared by the decoder and its branch evaluator.
// Assumes the constants header is included by the modules that need it.
package albd_pkg;
   typedef enum logic [3:0] {
      ALBD_OP_NONE = 4'h0,
      ALBD_OP_AND = 4'h1,
      ALBD_OP_TEST = 4'h2,
      ALBD_OP_OR = 4'h3,
      ALBD_OP_XOR = 4'h4,
      ALBD_OP_LOAD_STR = 4'h5,
      ALBD_OP_BRANCH = 4'h6,
      ALBD_OP_LOOP = 4'h7,
      ALBD_OP_CNT_BR = 4'h8
   } albd_op_type;

   typedef enum logic [1:0] {
      ALBD_FORM_NONE = 2'h0,
      ALBD_FORM_RM_REG = 2'h1,
      ALBD_FORM_IMM_RM = 2'h2,
      ALBD_FORM_IMM_ACC = 2'h3
   } albd_form_type;

   typedef enum logic [3:0] {
      ALBD_CC_ZERO = 4'h0,
      ALBD_CC_NZERO = 4'h1,
      ALBD_CC_NEG = 4'h2,
      ALBD_CC_NNEG = 4'h3,
      ALBD_CC_SGE = 4'h4,
      ALBD_CC_SGT = 4'h5,
      ALBD_CC_UGE = 4'h6,
      ALBD_CC_UGT = 4'h7,
      ALBD_CC_ULE = 4'h8,
      ALBD_CC_PODD = 4'h9,
      ALBD_CC_NOVF = 4'hA,
      ALBD_CC_LOOPEQ = 4'hB,
      ALBD_CC_CNT0 = 4'hC
   } albd_cond_type;

   // Result of one decoded instruction toward the execution unit
   typedef struct packed {
      albd_op_type op;
      albd_form_type form;
      albd_cond_type cond;
      logic word;
      logic reg_is_dest;
      logic writes_result;
      logic clears_cf_of;
      logic rm_is_reg;
      logic [1:0] mode;
      logic [2:0] reg_field;
      logic [2:0] rm_field;
      logic [15:0] disp;
      logic [15:0] imm;
   } albd_instr_type;

   // Architectural state the branch evaluator needs
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] count;
      logic [15:0] next_ip;
   } albd_arch_type;

   typedef struct packed {
      logic taken;
      logic [15:0] target;
      logic [15:0] new_count;
      logic count_write;
   } albd_branch_type;
endpackage

// File: design/albd_branch_eval.sv
// Branch condition evaluator for short conditional branches and count loops.
// Assumes flags and count arrive from the execution unit on the same clock.
`timescale 1ns/1ps
`include "albd_consts.svh"
module albd_branch_eval (
   input wire albd_pkg::albd_cond_type cond,
   input wire logic [7:0] disp,
   input wire albd_pkg::albd_arch_type arch,
   output albd_pkg::albd_branch_type result
);
   wire logic cf = arch.flags[`ALBD_FLAG_CF];
   wire logic pf = arch.flags[`ALBD_FLAG_PF];
   wire logic zf = arch.flags[`ALBD_FLAG_ZF];
   wire logic sf = arch.flags[`ALBD_FLAG_SF];
   wire logic of_flag = arch.flags[`ALBD_FLAG_OF];
   wire logic [15:0] dec_count = arch.count - 16'h0001;
   wire logic is_loop = (cond == albd_pkg::ALBD_CC_LOOPEQ);
   logic taken;

   always_comb begin
      unique case (cond)
         albd_pkg::ALBD_CC_ZERO: taken = zf;
         albd_pkg::ALBD_CC_NZERO: taken = !zf;
         albd_pkg::ALBD_CC_NEG: taken = sf;
         albd_pkg::ALBD_CC_NNEG: taken = !sf;
         albd_pkg::ALBD_CC_SGE: taken = (sf == of_flag);
         albd_pkg::ALBD_CC_SGT: taken = !zf && (sf == of_flag);
         albd_pkg::ALBD_CC_UGE: taken = !cf;
         albd_pkg::ALBD_CC_UGT: taken = !cf && !zf;
         albd_pkg::ALBD_CC_ULE: taken = cf || zf;
         albd_pkg::ALBD_CC_PODD: taken = !pf;
         albd_pkg::ALBD_CC_NOVF: taken = !of_flag;
         albd_pkg::ALBD_CC_LOOPEQ: taken = (dec_count != 16'h0000) && zf;
         albd_pkg::ALBD_CC_CNT0: taken = (arch.count == 16'h0000);
         default: taken = 1'b0;
      endcase
   end

   // Target is relative to the following instruction
   assign result.taken = taken;
   assign result.target = taken ? arch.next_ip + {{8{disp[7]}}, disp} : arch.next_ip;
   assign result.new_count = is_loop ? dec_count : arch.count;
   assign result.count_write = is_loop;
endmodule

// File: bench/albd_decoder_chk.sv
// Checker for the decoder: ties decoded outputs to opcode and architectural state.
// Assumes arch is held steady while an instruction is decoded.
`timescale 1ns/1ps
`include "albd_consts.svh"
module albd_decoder_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready,
   input wire albd_pkg::albd_arch_type arch,
   input wire logic instr_valid,
   input wire albd_pkg::albd_instr_type instr,
   input wire logic illegal_op,
   input wire albd_pkg::albd_branch_type branch
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Operation class
   // ----------------------------------------
   a_test_no_write: assert property (
      instr_valid && instr.op == albd_pkg::ALBD_OP_TEST |-> !instr.writes_result)
      else $error("flag-only test wrote a result");
   a_logic_clears: assert property (
      instr_valid && instr.op inside {albd_pkg::ALBD_OP_AND, albd_pkg::ALBD_OP_OR, albd_pkg::ALBD_OP_XOR}
      |-> instr.clears_cf_of && instr.writes_result)
      else $error("logical op flag or write control wrong");
   // ----------------------------------------
   // Branch conditions, flags sampled in the done cycle
   // ----------------------------------------
   a_zero_branch: assert property (
      instr_valid && instr.cond inside {albd_pkg::ALBD_CC_ZERO, albd_pkg::ALBD_CC_NZERO}
      && instr.op == albd_pkg::ALBD_OP_BRANCH
      |-> branch.taken == ($past(arch.flags[`ALBD_FLAG_ZF]) ^ (instr.cond == albd_pkg::ALBD_CC_NZERO)))
      else $error("zero branch decision wrong");
   a_sign_branch: assert property (
      instr_valid && instr.cond inside {albd_pkg::ALBD_CC_NEG, albd_pkg::ALBD_CC_NNEG}
      && instr.op == albd_pkg::ALBD_OP_BRANCH
      |-> branch.taken == ($past(arch.flags[`ALBD_FLAG_SF]) ^ (instr.cond == albd_pkg::ALBD_CC_NNEG)))
      else $error("sign branch decision wrong");
   a_ule_branch: assert property (
      instr_valid && instr.cond == albd_pkg::ALBD_CC_ULE && instr.op == albd_pkg::ALBD_OP_BRANCH
      |-> branch.taken == ($past(arch.flags[`ALBD_FLAG_CF]) | $past(arch.flags[`ALBD_FLAG_ZF])))
      else $error("below-or-equal decision wrong");
   a_branch_target: assert property (
      instr_valid && branch.taken |-> branch.target == $past(arch.next_ip) + instr.disp)
      else $error("taken target wrong");
   a_no_take_seq: assert property (
      instr_valid && !branch.taken
      && instr.op inside {albd_pkg::ALBD_OP_BRANCH, albd_pkg::ALBD_OP_LOOP, albd_pkg::ALBD_OP_CNT_BR}
      |-> branch.target == $past(arch.next_ip))
      else $error("untaken branch not sequential");
   a_loop_count: assert property (
      instr_valid && instr.op == albd_pkg::ALBD_OP_LOOP
      |-> branch.count_write && branch.new_count == $past(arch.count) - 16'h0001
      && branch.taken == ($past(arch.count) != 16'h0001 && $past(arch.flags[`ALBD_FLAG_ZF])))
      else $error("count loop wrong");
   a_count_empty: assert property (
      instr_valid && instr.op == albd_pkg::ALBD_OP_CNT_BR
      |-> !branch.count_write && branch.taken == ($past(arch.count) == 16'h0000))
      else $error("empty count branch wrong");
endmodule
bind albd_decoder albd_decoder_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .byte_valid(byte_valid),
   .byte_data(byte_data), .byte_ready(byte_ready), .arch(arch), .instr_valid(instr_valid), .instr(instr),
   .illegal_op(illegal_op), .branch(branch));

// File: bench/albd_prefetch_model.sv
// Prefetch queue model feeding instruction bytes to the decoder.
// Assumes the bench pushes at most one byte per cycle.
`timescale 1ns/1ps
module albd_prefetch_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic [7:0] push_byte,
   input wire logic byte_ready,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   logic [7:0] q[$];
   logic [7:0] last = 8'h00;
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'hFF;
   end
   always @(posedge core_clk) begin
      if (sys_rst) begin
         q.delete();
      end else begin
         if (byte_valid && byte_ready) begin
            last = q.pop_front();
         end
         if (push) begin
            q.push_back(push_byte);
         end
      end
      byte_valid <= (q.size() != 0);
      // Idle data inverted so a stale byte never looks valid
      byte_data <= (q.size() != 0) ? q[0] : ~last;
   end
endmodule

// File: bench/albd_decoder_bench.sv
// Self-checking bench for the decoder with a prefetch queue model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module albd_decoder_bench;
   logic core_clk, sys_rst, push, byte_valid, byte_ready, instr_valid, illegal_op;
   logic [7:0] push_byte, byte_data;
   albd_pkg::albd_arch_type arch;
   albd_pkg::albd_instr_type instr;
   albd_pkg::albd_branch_type branch;
   int mismatches = 0;
   int samples_checked = 0;
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   albd_prefetch_model i_feed (.core_clk(core_clk), .sys_rst(sys_rst), .push(push), .push_byte(push_byte),
      .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));
   albd_decoder i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .byte_valid(byte_valid), .byte_data(byte_data),
      .byte_ready(byte_ready), .arch(arch), .instr_valid(instr_valid), .instr(instr), .illegal_op(illegal_op),
      .branch(branch));
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // First byte in the low lane; waits for the decoded pulse
   task automatic issue(input logic [31:0] b, input int n);
      int i;
      @(negedge core_clk);
      for (i = 0; i < n; i++) begin
         push = 1'b1;
         push_byte = b[8*i +: 8];
         @(negedge core_clk);
      end
      push = 1'b0;
      for (i = 0; i < 60; i++) begin
         @(posedge core_clk);
         #1;
         if (instr_valid === 1'b1) begin
            return;
         end
      end
      mismatches++;
      report_and_stop();
   endtask
   task automatic lg(input logic [31:0] b, input int n, input logic [3:0] op, input logic [1:0] fm,
         input logic w, input logic [15:0] im, input logic [15:0] dp);
      issue(b, n);
      `CHK(instr.op, op)
      `CHK(instr.form, fm)
      `CHK(instr.word, w)
      `CHK(illegal_op, 1'b0)
      if (op < 4'h5) begin
         `CHK(instr.writes_result, op != 4'h2)
         `CHK(instr.clears_cf_of, 1'b1)
      end
      if (fm == 2'h1) begin
         `CHK(instr.reg_is_dest, b[1])
      end
      if (fm == 2'h1 || fm == 2'h2) begin
         `CHK(instr.rm_is_reg, b[15:14] == 2'h3)
         `CHK(instr.mode, b[15:14])
         `CHK(instr.reg_field, b[13:11])
      end
      if (fm[1]) begin
         `CHK(instr.imm, im)
      end
      if (b[15:14] != 2'h3) begin
         `CHK(instr.disp, dp)
      end
   endtask
   task automatic br(input logic [7:0] o, input logic [15:0] f, input logic [15:0] c, input logic t,
         input logic cw, input logic [15:0] nc);
      @(negedge core_clk);
      arch = {f, c, 16'h1000};
      issue({16'h0000, 8'hF0, o}, 2);
      `CHK(branch.taken, t)
      `CHK(branch.target, t ? 16'h0FF0 : 16'h1000)
      `CHK(branch.count_write, cw)
      if (cw) begin
         `CHK(branch.new_count, nc)
      end
   endtask
   task automatic sc_logic();
      lg(32'h0000C123, 2, 4'h1, 2'h1, 1'b1, 16'h0000, 16'h0000);
      lg(32'h1234E081, 4, 4'h1, 2'h2, 1'b1, 16'h1234, 16'h0000);
      lg(32'h00005A24, 2, 4'h1, 2'h3, 1'b0, 16'h005A, 16'h0000);
      lg(32'h0000D884, 2, 4'h2, 2'h1, 1'b0, 16'h0000, 16'h0000);
      lg(32'h1234C0F7, 4, 4'h2, 2'h2, 1'b1, 16'h1234, 16'h0000);
      lg(32'h000055A8, 2, 4'h2, 2'h3, 1'b0, 16'h0055, 16'h0000);
      lg(32'h12340E22, 4, 4'h1, 2'h1, 1'b0, 16'h0000, 16'h1234);
      lg(32'h0090460A, 3, 4'h3, 2'h1, 1'b0, 16'h0000, 16'hFF90);
      lg(32'h007FC880, 3, 4'h3, 2'h2, 1'b0, 16'h007F, 16'h0000);
      lg(32'h0012340D, 3, 4'h3, 2'h3, 1'b1, 16'h1234, 16'h0000);
      lg(32'h12348631, 4, 4'h4, 2'h1, 1'b1, 16'h0000, 16'h1234);
      lg(32'h0080F083, 3, 4'h4, 2'h2, 1'b1, 16'hFF80, 16'h0000);
      lg(32'h0000AA34, 2, 4'h4, 2'h3, 1'b0, 16'h00AA, 16'h0000);
      lg(32'h000000AC, 1, 4'h5, 2'h0, 1'b0, 16'h0000, 16'h0000);
      lg(32'h000000AD, 1, 4'h5, 2'h0, 1'b1, 16'h0000, 16'h0000);
      $display("logic and string forms done");
   endtask
   task automatic sc_branch();
      br(8'h74, 16'h0040, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h75, 16'h0040, 16'h0000, 1'b0, 1'b0, 16'h0000);
      br(8'h78, 16'h0080, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h79, 16'h0080, 16'h0000, 1'b0, 1'b0, 16'h0000);
      br(8'h7D, 16'h0880, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h7F, 16'h0080, 16'h0000, 1'b0, 1'b0, 16'h0000);
      br(8'h73, 16'h0001, 16'h0000, 1'b0, 1'b0, 16'h0000);
      br(8'h77, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h76, 16'h0001, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h7B, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'h71, 16'h0800, 16'h0000, 1'b0, 1'b0, 16'h0000);
      br(8'hE1, 16'h0040, 16'h0005, 1'b1, 1'b1, 16'h0004);
      br(8'hE1, 16'h0040, 16'h0001, 1'b0, 1'b1, 16'h0000);
      br(8'hE3, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000);
      br(8'hE3, 16'h0000, 16'h0002, 1'b0, 1'b0, 16'h0000);
      $display("branch forms done");
   endtask
   // Unknown opcode, then a reset that cuts a branch in half
   task automatic sc_fault();
      issue(32'h000000F4, 1);
      `CHK(illegal_op, 1'b1)
      @(negedge core_clk);
      push = 1'b1;
      push_byte = 8'h74;
      @(negedge core_clk);
      push = 1'b0;
      // Opcode is taken at the next edge, so reset lands before its displacement
      @(negedge core_clk);
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      `CHK(instr_valid, 1'b0)
      `CHK(byte_ready, 1'b0)
      sys_rst = 1'b0;
      br(8'h75, 16'h0000, 16'h0000, 1'b1, 1'b0, 16'h0000);
      $display("fault and reset done");
   endtask
   initial begin
      sys_rst = 1'b1;
      push = 1'b0;
      push_byte = 8'h00;
      arch = '0;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      sc_logic();
      sc_branch();
      sc_fault();
      report_and_stop();
   end
endmodule
